// [core/ivp_pkg.sv]
package ivp_pkg;
  // Slot numbers: lower number wins
  localparam int unsigned NUM_SLOTS = 32;
  localparam int unsigned SLOT_W = 5;
  localparam int unsigned VEC_W = 8;
  localparam int unsigned VEC_SCALE = 8;
  localparam logic [4:0] SLOT_RESET = 5'h01;
  localparam logic [4:0] SLOT_STACK = 5'h03;
  localparam logic [4:0] SLOT_TMR_HI = 5'h04;
  localparam logic [4:0] SLOT_EXT3 = 5'h05;
  localparam logic [4:0] SLOT_DAG1 = 5'h0b;
  localparam logic [4:0] SLOT_DAG2 = 5'h0c;
  localparam logic [4:0] SLOT_TMR_LO = 5'h0e;
  localparam logic [4:0] SLOT_ARITH = 5'h0f;
  localparam logic [4:0] SLOT_USER = 5'h18;
  localparam int unsigned NUM_EXT = 4;
  localparam int unsigned NUM_ARITH = 4;
  localparam int unsigned NUM_USER = 8;
  localparam logic [31:0] MASK_RESET_VAL = 32'h0000_0000;
  localparam logic [31:0] NMI_SLOTS = 32'h0000_0002;
endpackage : ivp_pkg

// [core/ivp_req_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface ivp_req_if;
  logic [31:0] pend;
  logic hit;
  logic [4:0] slot;
  modport src (output pend, input hit, input slot);
  modport enc (input pend, output hit, output slot);
endinterface : ivp_req_if
`default_nettype wire

// [core/ivp_prio_enc.sv]
`timescale 1ns/100ps
`default_nettype none
module ivp_prio_enc (
  ivp_req_if.enc req
);
  // Lowest set slot wins
  function automatic logic [4:0] ivp_first(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : ivp_first

  assign req.hit = |req.pend;
  assign req.slot = ivp_first(req.pend); // [RULE1]
endmodule : ivp_prio_enc
`default_nettype wire

// [core/ivp_top.sv]
// Overview of operation
// [RULE1] Each source owns a fixed slot, lower slots win, vector is 8x slot.
// [RULE2] Status or loop stack overflow or call stack full raises slot 3.
// [RULE3] Timer zero in high priority mode raises slot 4 (vector 0x20).
// [RULE4] Timer zero in low priority mode raises slot 14 (vector 0x70).
// [RULE5] First address generator buffer 7 wrap raises slot 11 (0x58).
// [RULE6] Second address generator buffer 15 wrap raises slot 12 (0x60).
// [RULE7] Reset is unmaskable at slot 1, external lines 3..0 take slots
// 5..8, arithmetic faults 15..18, software interrupts 24..31.
`timescale 1ns/100ps
`default_nettype none
module ivp_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Event sources
  input wire logic soft_reset_i,
  input wire logic stat_stack_ovf_i,
  input wire logic loop_stack_ovf_i,
  input wire logic program_counter_stack_full_i,
  input wire logic timer_expired_out_i,
  input wire logic timer_hi_prio_i,
  input wire logic [3:0] ext_request_lines_i,
  input wire logic [3:0] ext_edge_mode_i,
  input wire logic data_address_generator1_wrap_i,
  input wire logic data_address_generator2_wrap_i,
  input wire logic [3:0] arith_exc_i,
  input wire logic [7:0] user_sw_irq_i,
  // Sequencer side
  input wire logic [31:0] mask_i,
  input wire logic glob_en_i,
  input wire logic ack_i,
  output logic irq_req_o,
  output logic [4:0] slot_o,
  output logic [7:0] vector_o,
  output logic [31:0] latch_o
);
  // ****************************************
  // Source mapping
  // ****************************************
  logic [31:0] latch_ff;
  logic [31:0] nxt_latch;
  logic [3:0] ext_prev_ff;
  logic [31:0] raw_set;
  logic [31:0] eff_mask;
  logic [31:0] ack_clr;
  logic [3:0] ext_evt;
  logic [4:0] sel_slot;
  logic sel_hit;
  logic [4:0] slot_ff;
  logic [7:0] vector_ff;
  logic req_ff;
  ivp_req_if req_bus ();

  function automatic logic [7:0] ivp_vec(input logic [4:0] s);
    return {s, 3'h0}; // [RULE1]
  endfunction : ivp_vec

  // Edge or level per line; edge catches pulses shorter than service
  assign ext_evt = (ext_request_lines_i & ~ext_edge_mode_i) |
                   (ext_request_lines_i & ~ext_prev_ff & ext_edge_mode_i);

  always_comb begin
    raw_set = 32'h0000_0000;
    raw_set[ivp_pkg::SLOT_RESET] = soft_reset_i; // [RULE7]
    raw_set[ivp_pkg::SLOT_STACK] = stat_stack_ovf_i | loop_stack_ovf_i |
                                   program_counter_stack_full_i; // [RULE2]
    raw_set[ivp_pkg::SLOT_TMR_HI] = timer_expired_out_i &
                                    timer_hi_prio_i; // [RULE3]
    raw_set[ivp_pkg::SLOT_TMR_LO] = timer_expired_out_i &
                                    ~timer_hi_prio_i; // [RULE4]
    raw_set[ivp_pkg::SLOT_DAG1] = data_address_generator1_wrap_i; // [RULE5]
    raw_set[ivp_pkg::SLOT_DAG2] = data_address_generator2_wrap_i; // [RULE6]
    for (int i = 0; i < 4; i++) begin
      raw_set[5'(32'(ivp_pkg::SLOT_EXT3) + i)] = ext_evt[3 - i]; // [RULE7]
      raw_set[5'(32'(ivp_pkg::SLOT_ARITH) + i)] = arith_exc_i[i]; // [RULE7]
    end
    for (int j = 0; j < 8; j++) begin
      raw_set[5'(32'(ivp_pkg::SLOT_USER) + j)] = user_sw_irq_i[j]; // [RULE7]
    end
  end

  // ****************************************
  // Latch, mask and selection
  // ****************************************
  // Reset slot ignores mask and global enable
  assign eff_mask = ((mask_i & {32{glob_en_i}}) | ivp_pkg::NMI_SLOTS); // [RULE7]
  assign req_bus.pend = latch_ff & eff_mask;
  assign sel_hit = req_bus.hit;
  assign sel_slot = req_bus.slot;
  // Ack clears the presented slot; a new set that cycle wins
  assign ack_clr = (ack_i && req_ff) ? (32'h0000_0001 << slot_ff) :
                   32'h0000_0000;
  assign nxt_latch = (latch_ff & ~ack_clr) | raw_set;

  ivp_prio_enc u_enc (
    .req(req_bus)
  );

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      latch_ff <= 32'h0000_0000;
      ext_prev_ff <= 4'h0;
      req_ff <= 1'b0;
      slot_ff <= 5'h00;
      vector_ff <= 8'h00;
    end else begin
      latch_ff <= nxt_latch;
      ext_prev_ff <= ext_request_lines_i;
      req_ff <= sel_hit && !(ack_i && req_ff);
      slot_ff <= sel_slot; // [RULE1]
      vector_ff <= ivp_vec(sel_slot); // [RULE1]
    end
  end

  assign irq_req_o = req_ff;
  assign slot_o = slot_ff;
  assign vector_o = vector_ff;
  assign latch_o = latch_ff;
endmodule : ivp_top
`default_nettype wire

// [tb/ivp_top_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module ivp_top_assertions (
  // Watched ports
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ack_i,
  input wire logic [31:0] mask_i,
  input wire logic irq_req_o,
  input wire logic [4:0] slot_o,
  input wire logic [7:0] vector_o,
  input wire logic [31:0] latch_o
);
  logic [31:0] mask_ff;
  always_ff @(posedge clk_i) mask_ff <= mask_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  AST_VEC: assert property (
    irq_req_o |-> vector_o == {slot_o, 3'h0}) else $error("vector");
  AST_RSV: assert property (
    (latch_o & 32'h00f8_2605) == '0) else $error("reserved slot");
  AST_RST1: assert property (
    $rose(latch_o[1]) |=> slot_o == 5'h01) else $error("reset slot");
  AST_MASK: assert property (
    irq_req_o |-> mask_ff[slot_o] || slot_o == 5'h01) else $error("mask");
  AST_ACK: assert property (
    ack_i && irq_req_o |-> ##[1:2] !irq_req_o) else $error("ack");
  AST_HOLD: assert property (
    irq_req_o && !ack_i && !$past(ack_i) |=> irq_req_o) else $error("hold");
  AST_IDLE: assert property (
    (latch_o == '0) [*2] |-> !irq_req_o) else $error("idle");
  cover property (ack_i && irq_req_o);
  cover property (irq_req_o && slot_o == 5'h0e);
  cover property (irq_req_o && slot_o == 5'h1f);
endmodule : ivp_top_assertions
bind ivp_top ivp_top_assertions i_ivp_top_assertions (.clk_i, .nrst_i,
  .ack_i, .mask_i, .irq_req_o, .slot_o, .vector_o, .latch_o);
`default_nettype wire

// [tb/ivp_seq_model.sv]
`timescale 1ns/100ps
`default_nettype none
module ivp_seq_model (
  // Sequencer handshake
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic irq_req_i,
  input wire logic slow_i,
  output logic ack_o
);
  logic seen_ff, gap_ff;
  // Gap after ack: request may linger one cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {seen_ff, gap_ff, ack_o} <= 3'h0;
    end else begin
      seen_ff <= irq_req_i && !ack_o;
      gap_ff <= ack_o;
      ack_o <= irq_req_i && !ack_o && !gap_ff && (seen_ff || !slow_i);
    end
  end
endmodule : ivp_seq_model
`default_nettype wire

// [tb/ivp_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module ivp_tb_top;
  logic clk_i = 1'h0, nrst_i = 1'h0, timer_hi_prio_i = 1'h1;
  logic ack_i, irq_req_o;
  logic [4:0] slot_o;
  logic [7:0] vector_o;
  logic [22:0] s = '0;
  logic [31:0] mask_i = '1;
  int err_count = 0, checks = 0;
  always #12.5 clk_i = ~clk_i;
  ivp_top i_ivp_top (.clk_i, .nrst_i, .soft_reset_i(s[0]),
    .stat_stack_ovf_i(s[1]), .loop_stack_ovf_i(s[2]),
    .program_counter_stack_full_i(s[3]), .timer_expired_out_i(s[4]),
    .timer_hi_prio_i, .ext_request_lines_i(s[8:5]), .ext_edge_mode_i(4'h0),
    .data_address_generator1_wrap_i(s[9]), .glob_en_i(1'h1),
    .data_address_generator2_wrap_i(s[10]), .arith_exc_i(s[14:11]),
    .user_sw_irq_i(s[22:15]), .mask_i, .ack_i, .irq_req_o, .slot_o,
    .vector_o, .latch_o());
  ivp_seq_model i_ivp_seq_model (.clk_i, .nrst_i, .irq_req_i(irq_req_o),
    .slow_i(timer_hi_prio_i), .ack_o(ack_i));
  task stop_test;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : stop_test
  task wt(input logic v);
    @(negedge clk_i);
    for (int n = 0; irq_req_o !== v; n++) begin
      if (n == 40) err_count++;
      if (n == 40) stop_test;
      @(negedge clk_i);
    end
  endtask : wt
  task cmp(input logic [4:0] e);
    checks++;
    if ({slot_o, vector_o} !== {e, e, 3'h0}) begin
      err_count++;
      $display("Error slot_vector expected %h seen %h %h", e, slot_o, vector_o);
    end
  endtask : cmp
  function automatic logic [4:0] xs(int b);
    if (b == 0) return 5'h01;
    if (b < 4) return 5'h03;
    if (b == 4) return timer_hi_prio_i ? 5'h04 : 5'h0e;
    if (b < 9) return 5'(13 - b);
    return 5'(b < 11 ? b + 2 : (b < 15 ? b + 4 : b + 9));
  endfunction : xs
  task chk(input int b);
    wt(1'h0);
    @(posedge clk_i) s[b] <= 1'h1;
    @(posedge clk_i) s[b] <= 1'h0;
    wt(1'h1);
    cmp(xs(b));
  endtask : chk
  task t_map;
    for (int b = 0; b < 23; b++) chk(b);
  endtask : t_map
  task t_low;
    @(posedge clk_i) timer_hi_prio_i <= 1'h0;
    chk(4);
  endtask : t_low
  task t_prio;
    wt(1'h0);
    @(posedge clk_i) mask_i <= ~32'h20;
    s <= 23'h408100;
    @(posedge clk_i) s <= '0;
    wt(1'h1);
    cmp(5'h18);
    wt(1'h0);
    wt(1'h1);
    cmp(5'h1f);
    wt(1'h0);
    @(posedge clk_i) mask_i <= '1;
    wt(1'h1);
    cmp(5'h05);
  endtask : t_prio
  initial begin
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'h1;
    t_map;
    t_low;
    t_prio;
    stop_test;
  end
endmodule : ivp_tb_top
`default_nettype wire
